// >>> logic/lsmov_exec.sv
// execution of literal loads and working-register stores
// assumes the core supplies one raw instruction word per cycle, synchronous
`timescale 1ns/1ps
`default_nettype none
module lsmov_exec
	import lsmov_pkg::*;
(
	// clock and reset
	input  wire logic                    i_clock,
	input  wire logic                    i_rst,
	// instruction stream
	input  wire logic                    i_valid,
	input  wire logic [LSMOV_IW-1:0]     i_instr,
	// status flags from the core
	input  wire logic [2:0]              i_status,
	// architectural state
	output logic [LSMOV_BANK_W-1:0]      o_bank_select_reg,
	output logic [LSMOV_PAGE_W-1:0]      o_program_counter_high_latch,
	output logic [7:0]                   o_acc,
	output logic [LSMOV_PTR_W-1:0]       o_pointer_reg0,
	output logic [LSMOV_PTR_W-1:0]       o_pointer_reg1,
	output logic [2:0]                   o_status,
	// data memory write
	output lsmov_wr_t                    o_wr,
	output logic                         o_done
);
	lsmov_op_t                op;
	logic                     sel;
	lsmov_mode_t              mode;
	logic [LSMOV_PTR_W-1:0]   ptr;
	logic [LSMOV_PTR_W-1:0]   ptr_inc;
	logic [LSMOV_PTR_W-1:0]   ptr_dec;
	logic [LSMOV_PTR_W-1:0]   next_ptr;
	logic [LSMOV_PTR_W-1:0]   eff_addr;
	logic [LSMOV_PTR_W-1:0]   ofs_ext;

	// operand field widths inside the instruction word
	localparam int LSMOV_BANK_LIT_W = 4;
	localparam int LSMOV_LIT_W      = 8;
	localparam int LSMOV_MODE_W     = 2;

	// every check runs on the one clock and rests during reset
	default clocking lsmov_cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	// decode; literal load matches on upper bits only
	always_comb begin
		op = LSMOV_OP_NONE;
		if (i_valid) begin
			if ((i_instr & LSMOV_MASK_STK) == LSMOV_CODE_STK)
				op = LSMOV_OP_STK;
			else if ((i_instr & LSMOV_MASK_PAGE) == LSMOV_CODE_PAGE)
				op = LSMOV_OP_PAGE;
			else if ((i_instr & LSMOV_MASK_LIT) == LSMOV_CODE_LIT)
				op = LSMOV_OP_LIT;
			else if ((i_instr & LSMOV_MASK_BANK) == LSMOV_CODE_BANK)
				op = LSMOV_OP_BANK;
			else if ((i_instr & LSMOV_MASK_STF) == LSMOV_CODE_STF)
				op = LSMOV_OP_STF;
			else if ((i_instr & LSMOV_MASK_STI) == LSMOV_CODE_STI)
				op = LSMOV_OP_STI;
		end
	end

	// pointer choice and address arithmetic
	always_comb begin
		sel = (op == LSMOV_OP_STK) ? i_instr[LSMOV_STK_N_BIT]
			: i_instr[LSMOV_STI_N_BIT];
		mode = lsmov_mode_t'(i_instr[LSMOV_MODE_W-1:0]);
		ptr = sel ? o_pointer_reg1 : o_pointer_reg0;
		// 16-bit adds drop the carry, giving the wrap
		ptr_inc = ptr + LSMOV_PTR_ONE;
		ptr_dec = ptr - LSMOV_PTR_ONE;
		ofs_ext = {{(LSMOV_PTR_W-LSMOV_OFS_W){i_instr[LSMOV_OFS_W-1]}},
			i_instr[LSMOV_OFS_W-1:0]};
		next_ptr = ptr;
		eff_addr = ptr;
		if (op == LSMOV_OP_STK) begin
			eff_addr = ptr + ofs_ext;
		end else begin
			case (mode)
				LSMOV_PRE_INC: begin
					next_ptr = ptr_inc;
					eff_addr = ptr_inc;
				end
				LSMOV_PRE_DEC: begin
					next_ptr = ptr_dec;
					eff_addr = ptr_dec;
				end
				LSMOV_POST_INC: begin
					next_ptr = ptr_inc;
					eff_addr = ptr;
				end
				LSMOV_POST_DEC: begin
					next_ptr = ptr_dec;
					eff_addr = ptr;
				end
				default: begin
					next_ptr = ptr;
					eff_addr = ptr;
				end
			endcase
		end
	end

	// bank select register; literal limited to 0..15
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst)
			o_bank_select_reg <= '0;
		else if (op == LSMOV_OP_BANK)
			o_bank_select_reg <= {{(LSMOV_BANK_W-LSMOV_BANK_LIT_W){1'b0}},
				i_instr[LSMOV_BANK_LIT_W-1:0]};
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst)
			o_program_counter_high_latch <= '0;
		else if (op == LSMOV_OP_PAGE)
			o_program_counter_high_latch <=
				i_instr[LSMOV_PAGE_W-1:0];
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst)
			o_acc <= '0;
		else if (op == LSMOV_OP_LIT)
			o_acc <= i_instr[LSMOV_LIT_W-1:0];
	end

	// relative form leaves the pointer alone
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_pointer_reg0 <= LSMOV_PTR_RST;
			o_pointer_reg1 <= LSMOV_PTR_RST;
		end else if (op == LSMOV_OP_STI) begin
			if (sel)
				o_pointer_reg1 <= next_ptr;
			else
				o_pointer_reg0 <= next_ptr;
		end
	end

	// flags pass through; nothing here computes them
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst)
			o_status <= '0;
		else
			o_status <= i_status;
	end

	// write port: file address or pointed address, never the port itself
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_wr <= '0;
		end else begin
			o_wr.en <= (op == LSMOV_OP_STF) || (op == LSMOV_OP_STI)
				|| (op == LSMOV_OP_STK);
			o_wr.data <= o_acc;
			o_wr.direct <= (op == LSMOV_OP_STF);
			if (op == LSMOV_OP_STF)
				o_wr.addr <= {{(LSMOV_PTR_W-LSMOV_FADDR_W){1'b0}},
					i_instr[LSMOV_FADDR_W-1:0]};
			else
				o_wr.addr <= eff_addr;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst)
			o_done <= 1'b0;
		else
			o_done <= (op != LSMOV_OP_NONE);
	end

	AST_BANK_LOAD: assert property (
		op == LSMOV_OP_BANK |=> o_bank_select_reg ==
			{1'b0, $past(i_instr[3:0])})
		else $error("bank select load wrong");

	AST_BANK_KEEP: assert property (
		op != LSMOV_OP_BANK |=> $stable(o_bank_select_reg))
		else $error("bank select changed without a load");

	AST_BANK_RANGE: assert property (
		o_bank_select_reg <= LSMOV_BANK_MAX)
		else $error("bank select out of range");

	AST_PAGE_LOAD: assert property (
		op == LSMOV_OP_PAGE |=> o_program_counter_high_latch ==
			$past(i_instr[6:0]))
		else $error("page latch load wrong");

	AST_PAGE_KEEP: assert property (
		op != LSMOV_OP_PAGE |=> $stable(o_program_counter_high_latch))
		else $error("page latch changed without a load");

	AST_ACC_LOAD: assert property (
		op == LSMOV_OP_LIT |=> o_acc == $past(i_instr[7:0]))
		else $error("working register load wrong");

	AST_ACC_KEEP: assert property (
		op != LSMOV_OP_LIT |=> $stable(o_acc))
		else $error("working register changed without a load");

	AST_LIT_DONTCARE: assert property (
		i_valid && i_instr[13:10] == 4'hC && i_instr[9:7] != 3'h3
		|-> op == LSMOV_OP_LIT)
		else $error("literal load not decoded");

	AST_FILE_STORE: assert property (
		op == LSMOV_OP_STF |=> o_wr.en && o_wr.direct
			&& o_wr.data == $past(o_acc)
			&& o_wr.addr == {9'h000, $past(i_instr[6:0])})
		else $error("file store wrong");

	AST_IND_SEL: assert property (
		op == LSMOV_OP_STI && !sel |=> o_pointer_reg1 ==
			$past(o_pointer_reg1))
		else $error("wrong pointer updated");

	AST_IND_SEL1: assert property (
		op == LSMOV_OP_STI && sel |=> o_pointer_reg0 ==
			$past(o_pointer_reg0))
		else $error("wrong pointer updated");

	AST_IND_DATA: assert property (
		(op == LSMOV_OP_STI || op == LSMOV_OP_STK) |=> o_wr.en
			&& !o_wr.direct && o_wr.data == $past(o_acc))
		else $error("indirect store wrong");

	AST_PRE_INC: assert property (
		op == LSMOV_OP_STI && mode == LSMOV_PRE_INC && sel
		|=> o_wr.addr == o_pointer_reg1
			&& o_pointer_reg1 == $past(o_pointer_reg1) + 16'h0001)
		else $error("pre increment wrong");

	AST_PRE_DEC: assert property (
		op == LSMOV_OP_STI && mode == LSMOV_PRE_DEC && sel
		|=> o_wr.addr == o_pointer_reg1
			&& o_pointer_reg1 == $past(o_pointer_reg1) - 16'h0001)
		else $error("pre decrement wrong");

	AST_POST_INC: assert property (
		op == LSMOV_OP_STI && mode == LSMOV_POST_INC && !sel
		|=> o_wr.addr == $past(o_pointer_reg0)
			&& o_pointer_reg0 == $past(o_pointer_reg0) + 16'h0001)
		else $error("post increment wrong");

	AST_POST_DEC: assert property (
		op == LSMOV_OP_STI && mode == LSMOV_POST_DEC && !sel
		|=> o_wr.addr == $past(o_pointer_reg0)
			&& o_pointer_reg0 == $past(o_pointer_reg0) - 16'h0001)
		else $error("post decrement wrong");

	AST_REL_ADDR: assert property (
		op == LSMOV_OP_STK |=> o_wr.addr ==
			$past(sel ? o_pointer_reg1 : o_pointer_reg0)
			+ {{(LSMOV_PTR_W-LSMOV_OFS_W)
				{$past(i_instr[LSMOV_OFS_W-1])}},
			$past(i_instr[LSMOV_OFS_W-1:0])})
		else $error("relative address wrong");

	AST_REL_KEEP: assert property (
		op == LSMOV_OP_STK |=> o_pointer_reg0 == $past(o_pointer_reg0)
			&& o_pointer_reg1 == $past(o_pointer_reg1))
		else $error("relative store moved pointer");

	AST_WRAP: assert property (
		op == LSMOV_OP_STI && !sel && mode == LSMOV_PRE_INC
		&& o_pointer_reg0 == 16'hFFFF |=> o_pointer_reg0 == 16'h0000
			&& o_wr.addr == 16'h0000)
		else $error("pointer did not wrap");

	AST_WRAP_DEC: assert property (
		op == LSMOV_OP_STI && sel && mode == LSMOV_PRE_DEC
		&& o_pointer_reg1 == 16'h0000 |=> o_pointer_reg1 == 16'hFFFF
			&& o_wr.addr == 16'hFFFF)
		else $error("pointer did not wrap downwards");

	AST_FLAGS: assert property (
		1'b1 |=> o_status == $past(i_status))
		else $error("status flags altered");

	AST_QUIET: assert property (
		op == LSMOV_OP_NONE |=> !o_wr.en && !o_done
			&& $stable(o_pointer_reg0) && $stable(o_pointer_reg1))
		else $error("unrecognised word had an effect");

	AST_ONE_CYCLE: assert property (
		op != LSMOV_OP_NONE |=> o_done
			##1 (!o_done || $past(i_valid)))
		else $error("move not done in one cycle");
endmodule
`default_nettype wire

// >>> logic/lsmov_pkg.sv
// package for the literal and store move execution block
// assumes a 14-bit instruction word presented with a one-cycle valid strobe
package lsmov_pkg;
	localparam int LSMOV_IW      = 14;
	localparam int LSMOV_PTR_W   = 16;
	localparam int LSMOV_BANK_W  = 5;
	localparam int LSMOV_PAGE_W  = 7;
	localparam int LSMOV_FADDR_W = 7;
	localparam int LSMOV_OFS_W   = 6;
	// opcode patterns, match after masking
	localparam logic [13:0] LSMOV_MASK_BANK = 14'h3FE0;
	localparam logic [13:0] LSMOV_CODE_BANK = 14'h0020;
	localparam logic [13:0] LSMOV_MASK_PAGE = 14'h3F80;
	localparam logic [13:0] LSMOV_CODE_PAGE = 14'h3180;
	// bits 9:8 of the literal load are don't-care; page pattern wins first
	localparam logic [13:0] LSMOV_MASK_LIT  = 14'h3C00;
	localparam logic [13:0] LSMOV_CODE_LIT  = 14'h3000;
	localparam logic [13:0] LSMOV_MASK_STF  = 14'h3F80;
	localparam logic [13:0] LSMOV_CODE_STF  = 14'h0080;
	localparam logic [13:0] LSMOV_MASK_STI  = 14'h3FF8;
	localparam logic [13:0] LSMOV_CODE_STI  = 14'h0018;
	localparam logic [13:0] LSMOV_MASK_STK  = 14'h3F80;
	localparam logic [13:0] LSMOV_CODE_STK  = 14'h3F80;
	// field positions, bank limit and pointer constants
	localparam int LSMOV_STI_N_BIT = 2;
	localparam int LSMOV_STK_N_BIT = 6;
	localparam int LSMOV_BANK_MAX  = 15;
	localparam logic [LSMOV_PTR_W-1:0] LSMOV_PTR_ONE = 16'h0001;
	localparam logic [LSMOV_PTR_W-1:0] LSMOV_PTR_RST = 16'h0000;

	typedef enum logic [1:0] {
		LSMOV_PRE_INC  = 2'b00,
		LSMOV_PRE_DEC  = 2'b01,
		LSMOV_POST_INC = 2'b10,
		LSMOV_POST_DEC = 2'b11
	} lsmov_mode_t;

	typedef enum logic [2:0] {
		LSMOV_OP_NONE = 3'b000,
		LSMOV_OP_BANK = 3'b001,
		LSMOV_OP_PAGE = 3'b010,
		LSMOV_OP_LIT  = 3'b011,
		LSMOV_OP_STF  = 3'b100,
		LSMOV_OP_STI  = 3'b101,
		LSMOV_OP_STK  = 3'b110
	} lsmov_op_t;

	// one data memory write request
	typedef struct packed {
		logic                   en;
		logic [LSMOV_PTR_W-1:0] addr;
		logic [7:0]             data;
		logic                   direct;
	} lsmov_wr_t;
endpackage

// >>> verif/tb_top.sv
// self-checking bench for the literal and store move execution block
// assumes lsmov_pkg is compiled first; inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import lsmov_pkg::*;
	logic                   i_clock  = 1'b0;
	logic                   i_rst    = 1'b1;
	logic                   i_valid  = 1'b0;
	logic [LSMOV_IW-1:0]    i_instr  = 14'h0000;
	logic [2:0]             i_status = 3'h5;
	logic [LSMOV_BANK_W-1:0] o_bank_select_reg;
	logic [LSMOV_PAGE_W-1:0] o_program_counter_high_latch;
	logic [7:0]             o_acc;
	logic [LSMOV_PTR_W-1:0] o_pointer_reg0;
	logic [LSMOV_PTR_W-1:0] o_pointer_reg1;
	logic [2:0]             o_status;
	lsmov_wr_t              o_wr;
	logic                   o_done;
	int                     fails   = 0;
	int                     checked = 0;
	logic [15:0]            ptr [2] = '{16'h0000, 16'h0000};

	always #12.5 i_clock = ~i_clock;

	lsmov_exec lsmov_exec_inst (
		.i_clock(i_clock), .i_rst(i_rst), .i_valid(i_valid),
		.i_instr(i_instr), .i_status(i_status),
		.o_bank_select_reg(o_bank_select_reg),
		.o_program_counter_high_latch(o_program_counter_high_latch),
		.o_acc(o_acc), .o_pointer_reg0(o_pointer_reg0),
		.o_pointer_reg1(o_pointer_reg1), .o_status(o_status),
		.o_wr(o_wr), .o_done(o_done)
	);

	task automatic chk(input string what, input logic [15:0] exp,
			input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// valid stays high so back-to-back words need no gap
	task automatic op(input logic [13:0] w);
		i_valid = 1'b1;
		i_instr = w;
		@(negedge i_clock);
	endtask

	task automatic idle;
		i_valid = 1'b0;
		@(negedge i_clock);
	endtask

	task automatic t_lit;
		op(14'h305A);
		chk("acc", 16'h005A, o_acc);
		chk("done", 16'h0001, o_done);
		op(14'h33A5);
		chk("acc dont care", 16'h00A5, o_acc);
		chk("status", 16'h0005, o_status);
		idle();
	endtask

	task automatic t_bank_page;
		op(14'h002F);
		chk("bank", 16'h000F, o_bank_select_reg);
		op(14'h31FF);
		chk("page", 16'h007F, o_program_counter_high_latch);
		chk("bank kept", 16'h000F, o_bank_select_reg);
		op(14'h0020);
		chk("bank zero", 16'h0000, o_bank_select_reg);
		chk("status", 16'h0005, o_status);
		idle();
	endtask

	// literal then store back to back: store must see the new value
	task automatic t_file;
		op(14'h30C3);
		op(14'h00FF);
		chk("wr en", 16'h0001, o_wr.en);
		chk("wr direct", 16'h0001, o_wr.direct);
		chk("wr addr", 16'h007F, o_wr.addr);
		chk("wr data", 16'h00C3, o_wr.data);
		idle();
		chk("wr pulse", 16'h0000, o_wr.en);
	endtask

	// mode order chosen so every step wraps through zero
	task automatic t_ind;
		logic [1:0]  m;
		logic [15:0] nv;
		logic [15:0] ea;
		for (int n = 0; n < 2; n++) begin
			for (int k = 0; k < 4; k++) begin
				m = 2'(k) ^ 2'b01;
				nv = m[0] ? ptr[n] - 16'h0001 : ptr[n] + 16'h0001;
				ea = m[1] ? ptr[n] : nv;
				ptr[n] = nv;
				op(14'h0018 | 14'(n * 4 + int'(m)));
				chk("ind en", 16'h0001, o_wr.en);
				chk("ind direct", 16'h0000, o_wr.direct);
				chk("ind addr", ea, o_wr.addr);
				chk("ind data", 16'h00C3, o_wr.data);
				chk("ptr0", ptr[0], o_pointer_reg0);
				chk("ptr1", ptr[1], o_pointer_reg1);
				chk("status", 16'h0005, o_status);
			end
		end
		idle();
	endtask

	task automatic t_rel;
		op(14'h3FA0);
		chk("rel addr lo", ptr[0] - 16'h0020, o_wr.addr);
		chk("rel ptr0", ptr[0], o_pointer_reg0);
		op(14'h3FDF);
		chk("rel addr hi", ptr[1] + 16'h001F, o_wr.addr);
		chk("rel ptr1", ptr[1], o_pointer_reg1);
		chk("rel data", 16'h00C3, o_wr.data);
		idle();
	endtask

	task automatic t_unmatched;
		i_status = 3'h2;
		op(14'h0000);
		chk("no done", 16'h0000, o_done);
		chk("no write", 16'h0000, o_wr.en);
		chk("acc kept", 16'h00C3, o_acc);
		chk("status follow", 16'h0002, o_status);
		idle();
	endtask

	// reset in mid-run: bank, page, ptr0, write, done and status outputs must be clear by the next falling edge
	task automatic t_reset;
		op(14'h0025);
		op(14'h0019);
		chk("pre rst ptr0", 16'hFFFF, o_pointer_reg0);
		i_valid = 1'b0;
		i_rst = 1'b1;
		@(negedge i_clock);
		chk("rst bank", 16'h0000, o_bank_select_reg);
		chk("rst page", 16'h0000, o_program_counter_high_latch);
		chk("rst ptr0 mid", 16'h0000, o_pointer_reg0);
		chk("rst wr", 16'h0000, o_wr.en);
		chk("rst done", 16'h0000, o_done);
		chk("rst status", 16'h0000, o_status);
		i_rst = 1'b0;
		ptr[0] = 16'h0000;
		op(14'h0018);
		chk("ptr after rst", 16'h0001, o_pointer_reg0);
		chk("data after rst", 16'h0000, o_wr.data);
		idle();
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(negedge i_clock);
		chk("rst acc", 16'h0000, o_acc);
		chk("rst ptr0", 16'h0000, o_pointer_reg0);
		i_rst = 1'b0;
		t_lit();
		t_bank_page();
		t_file();
		t_ind();
		t_rel();
		t_unmatched();
		t_reset();
		close_out();
	end

	// whole run is about 32 cycles; this allows ample margin
	initial begin
		#5000;
		fails++;
		close_out();
	end
endmodule
`default_nettype wire
